// ### dmrd_mode_regs.sv
/*
 * upper-byte calibration invert, command/address buffer speed select
 * and termination control mode registers of one channel.
 * assumes mode register writes arrive on the command clock lnk_clk,
 * the operating set-point select and calibration data come from logic on sys_clk; the write select comes with the write.
 */
`timescale 1ns/10ps
`default_nettype none

// Contract
// - write-only 8-bit register at address 14H selects upper-byte pattern inversion.
// - bit 0 keeps a lane's calibration pattern true, bit 1 inverts it.
// - invert register holds 55H after initialization until rewritten.
// - bits 0..3 steer DQ8..DQ11, bits 4..7 steer DQ12..DQ15.
// - upper mask/invert lane always sends the true pattern.
// - no bus inversion during read calibration, even if enabled.
// - write-only register at address 15H holds the low-speed buffer bit.
// - bit 5 selects normal buffer at 0 (default), low-speed at 1.
// - a write updates only the copy named by the write set-point select.
// - device runs only from the copy named by the operating select.
// - a device without the low-speed buffer ignores that bit.
// - write register at address 16H holds controller value and termination controls.
// - bits 2:0 give controller value: 0 off, 1..6 reference divided, 7 reserved.
// - bit 3 at 0 enables clock termination, at 1 disables it.
// - bit 4 at 0 enables chip-select termination, at 1 disables it.
// - bit 5 at 0 enables command/address termination, at 1 disables it.
// - byte mode bit 6 at 1 disables all termination for the lower-byte device.
// - byte mode bit 7 at 1 disables all termination for the upper-byte device.
// - the bond pin is ignored; termination comes only from mode registers.
module dmrd_mode_regs
    import dmrd_pkg::*;
#(
    parameter bit LOW_SPEED_SUPPORTED = 1'b1
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic lnk_clk,
    input wire logic mode_write_command,
    input wire dmrd_addr_t mrw_addr,
    input wire dmrd_byte_t mrw_op,
    input wire logic write_set_point_select,
    input wire logic operating_set_point_select,
    input wire logic term_value_ca_enable,
    input wire logic byte_mode,
    input wire logic upper_byte_device,
    input wire logic term_bond_pin,
    input wire logic cal_active,
    input wire logic cal_bit,
    input wire logic dbi_read_enable,
    output logic mrw_busy,
    output logic mrw_applied,
    output dmrd_byte_t dq_cal_upper,
    output logic upper_mask_invert_lane,
    output logic dbi_apply,
    output logic ca_low_speed_sel,
    output dmrd_odt_code_t soc_odt_code,
    output logic soc_odt_enable,
    output logic soc_odt_reserved,
    output logic ck_term_en,
    output logic cs_term_en,
    output logic ca_term_en,
    output logic term_bond_seen
);
    // address match used by several decoders
    function automatic logic addr_hit(input dmrd_addr_t a, input dmrd_addr_t t);
        addr_hit = (a == t);
    endfunction

    // link side: capture write and signal it by toggle
    dmrd_link_state_t lnk_state_r;
    logic lnk_rst;
    logic lnk_tog_r;
    logic lnk_ack;
    dmrd_addr_t lnk_addr_r;
    dmrd_byte_t lnk_op_r;
    logic lnk_wsel_r;

    dmrd_sync u_lnk_rst_sync (
        .clk(lnk_clk),
        .rst(1'b0),
        .async_in(srst),
        .sync_out(lnk_rst)
    );

    always_ff @(posedge lnk_clk) begin
        if (lnk_rst) begin
            lnk_state_r <= DMRD_LINK_IDLE;
        end else begin
            unique case (lnk_state_r)
                DMRD_LINK_IDLE: begin
                    if (mode_write_command) begin
                        lnk_state_r <= DMRD_LINK_HOLD;
                    end
                end
                DMRD_LINK_HOLD: begin
                    if (lnk_ack == lnk_tog_r) begin
                        lnk_state_r <= DMRD_LINK_IDLE;
                    end
                end
            endcase
        end
    end

    // word stays still until the system side echoes the toggle
    always_ff @(posedge lnk_clk) begin
        if (lnk_rst) begin
            lnk_addr_r <= 6'h00;
            lnk_op_r <= 8'h00;
            lnk_wsel_r <= 1'b0;
        end else if (lnk_state_r == DMRD_LINK_IDLE && mode_write_command) begin
            lnk_addr_r <= mrw_addr;
            lnk_op_r <= mrw_op;
            lnk_wsel_r <= write_set_point_select;
        end
    end

    always_ff @(posedge lnk_clk) begin
        if (lnk_rst) begin
            lnk_tog_r <= 1'b0;
        end else if (lnk_state_r == DMRD_LINK_IDLE && mode_write_command) begin
            lnk_tog_r <= ~lnk_tog_r;
        end
    end

    // system side: receive toggle, echo it back
    logic sys_tog;
    logic sys_seen_r;
    logic wr_evt;

    dmrd_sync u_req_sync (
        .clk(sys_clk),
        .rst(srst),
        .async_in(lnk_tog_r),
        .sync_out(sys_tog)
    );

    dmrd_sync u_ack_sync (
        .clk(lnk_clk),
        .rst(lnk_rst),
        .async_in(sys_seen_r),
        .sync_out(lnk_ack)
    );

    assign wr_evt = (sys_tog != sys_seen_r);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sys_seen_r <= 1'b0;
        end else begin
            sys_seen_r <= sys_tog;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mrw_applied <= 1'b0;
        end else begin
            mrw_applied <= wr_evt;
        end
    end

    assign mrw_busy = (sys_tog != sys_seen_r) || (lnk_tog_r != sys_seen_r);

    // write decode, stable while the toggle is outstanding
    logic wr_invert;
    logic [1:0] wr_fsp;
    dmrd_byte_t fsp_rst [2];
    dmrd_addr_t fsp_addr [2];
    dmrd_byte_t fsp_wdata [2];
    dmrd_byte_t fsp_val [2];

    assign wr_invert = wr_evt && addr_hit(lnk_addr_r, `DMRD_ADDR_UPPER_INVERT);
    assign fsp_addr[0] = `DMRD_ADDR_CA_SPEED;
    assign fsp_addr[1] = `DMRD_ADDR_TERM_CTRL;
    assign fsp_rst[0] = `DMRD_RST_CA_SPEED;
    assign fsp_rst[1] = `DMRD_RST_TERM_CTRL;
    // reserved bits of speed select are dropped before storage
    assign fsp_wdata[0] = lnk_op_r & (8'h01 << `DMRD_LOW_SPEED_BIT);
    assign fsp_wdata[1] = lnk_op_r;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_fsp
            assign wr_fsp[gi] = wr_evt && addr_hit(lnk_addr_r, fsp_addr[gi]);
            dmrd_fsp_reg #(
                .RST_VAL(gi == 0 ? `DMRD_RST_CA_SPEED : `DMRD_RST_TERM_CTRL)
            ) u_reg (
                .clk(sys_clk),
                .rst(srst),
                .wr_en(wr_fsp[gi]),
                .wr_sel(lnk_wsel_r),
                .wr_data(fsp_wdata[gi]),
                .op_sel(operating_set_point_select),
                .active_val(fsp_val[gi])
            );
        end
    endgenerate

    // single-copy invert register
    dmrd_byte_t invert_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            invert_r <= `DMRD_RST_UPPER_INVERT;
        end else if (wr_invert) begin
            invert_r <= lnk_op_r;
        end
    end

    // calibration pattern drive on the upper byte
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dq_cal_upper <= 8'h00;
        end else begin
            // bit n steers DQ(8+n), set bit inverts
            dq_cal_upper <= {8{cal_bit}} ^ invert_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            upper_mask_invert_lane <= 1'b0;
        end else begin
            upper_mask_invert_lane <= cal_bit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dbi_apply <= 1'b0;
        end else begin
            dbi_apply <= dbi_read_enable && !cal_active;
        end
    end

    // buffer speed select from the active copy
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ca_low_speed_sel <= 1'b0;
        end else begin
            ca_low_speed_sel <= LOW_SPEED_SUPPORTED && fsp_val[0][`DMRD_LOW_SPEED_BIT];
        end
    end

    // controller odt value
    dmrd_odt_code_t odt_code;

    assign odt_code = fsp_val[1][`DMRD_SOC_ODT_HI:`DMRD_SOC_ODT_LO];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            soc_odt_code <= `DMRD_SOC_ODT_OFF;
            soc_odt_enable <= 1'b0;
            soc_odt_reserved <= 1'b0;
        end else begin
            soc_odt_code <= odt_code;
            soc_odt_enable <= (odt_code != `DMRD_SOC_ODT_OFF) && (odt_code != `DMRD_SOC_ODT_RSVD);
            soc_odt_reserved <= (odt_code == `DMRD_SOC_ODT_RSVD);
        end
    end

    // termination enables; bond pin plays no part
    logic byte_off;

    assign byte_off = byte_mode && (upper_byte_device ?
                      fsp_val[1][`DMRD_UPPER_BYTE_BIT] :
                      fsp_val[1][`DMRD_LOWER_BYTE_BIT]);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ck_term_en <= 1'b0;
            cs_term_en <= 1'b0;
            ca_term_en <= 1'b0;
        end else begin
            ck_term_en <= term_value_ca_enable && !fsp_val[1][`DMRD_CK_TERM_BIT] && !byte_off;
            cs_term_en <= term_value_ca_enable && !fsp_val[1][`DMRD_CS_TERM_BIT] && !byte_off;
            ca_term_en <= term_value_ca_enable && !fsp_val[1][`DMRD_CA_TERM_BIT] && !byte_off;
        end
    end

    // bond pin level is only reported, never used
    dmrd_sync u_bond_sync (
        .clk(sys_clk),
        .rst(srst),
        .async_in(term_bond_pin),
        .sync_out(term_bond_seen)
    );
endmodule

`default_nettype wire

// ### dmrd_cfg.svh
/*
 * constants of the mode register group: addresses, field positions,
 * reset values and the limits that go with the low-speed buffer.
 * assumes inclusion by bare name from the package and the top module.
 */
`ifndef DMRD_CFG_SVH
`define DMRD_CFG_SVH

// mode register addresses
`define DMRD_ADDR_UPPER_INVERT 6'h14
`define DMRD_ADDR_CA_SPEED 6'h15
`define DMRD_ADDR_TERM_CTRL 6'h16

// reset values
`define DMRD_RST_UPPER_INVERT 8'h55
`define DMRD_RST_CA_SPEED 8'h00
`define DMRD_RST_TERM_CTRL 8'h00

// speed select field
`define DMRD_LOW_SPEED_BIT 5

// termination control fields
`define DMRD_SOC_ODT_HI 2
`define DMRD_SOC_ODT_LO 0
`define DMRD_CK_TERM_BIT 3
`define DMRD_CS_TERM_BIT 4
`define DMRD_CA_TERM_BIT 5
`define DMRD_LOWER_BYTE_BIT 6
`define DMRD_UPPER_BYTE_BIT 7
`define DMRD_SOC_ODT_OFF 3'h0
`define DMRD_SOC_ODT_RSVD 3'h7

// low-speed buffer clock ceiling, kept for the controller side
`define DMRD_LOW_SPEED_MAX_MHZ 800

// set-point copies of a duplicated register
`define DMRD_SET_POINTS 2

`endif

// ### dmrd_pkg.sv
/*
 * types shared by the mode register group.
 * assumes dmrd_cfg.svh is on the include path.
 */
`include "dmrd_cfg.svh"

package dmrd_pkg;
    typedef logic [7:0] dmrd_byte_t;
    typedef logic [5:0] dmrd_addr_t;
    typedef logic [2:0] dmrd_odt_code_t;
    typedef enum {
        DMRD_LINK_IDLE,
        DMRD_LINK_HOLD
    } dmrd_link_state_t;
endpackage

// ### dmrd_sync.sv
/*
 * three-flop level synchroniser; a change is passed on once the
 * second and third flops agree. assumes the destination clock on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module dmrd_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;
    logic mid_r;
    logic late_r;

    always_ff @(posedge clk) begin
        meta_r <= async_in;
        mid_r <= meta_r;
        late_r <= mid_r;
    end

    // accepted value moves only when the two later stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_out <= 1'b0;
        end else if (mid_r == late_r) begin
            sync_out <= late_r;
        end
    end
endmodule

`default_nettype wire

// ### dmrd_fsp_reg.sv
/*
 * one 8-bit mode register held in two set-point copies.
 * assumes the write strobe, data and selects are on the clk domain.
 */
`timescale 1ns/10ps
`default_nettype none

module dmrd_fsp_reg
    import dmrd_pkg::*;
#(
    parameter dmrd_byte_t RST_VAL = 8'h00
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire dmrd_byte_t wr_data,
    input wire logic op_sel,
    output dmrd_byte_t active_val
);
    dmrd_byte_t copy_r [`DMRD_SET_POINTS];

    // only the addressed copy takes the write
    always_ff @(posedge clk) begin
        if (rst) begin
            copy_r[0] <= RST_VAL;
            copy_r[1] <= RST_VAL;
        end else if (wr_en) begin
            copy_r[wr_sel] <= wr_data;
        end
    end

    // the inactive copy never reaches the output
    always_ff @(posedge clk) begin
        if (rst) begin
            active_val <= RST_VAL;
        end else begin
            active_val <= copy_r[op_sel];
        end
    end
endmodule

`default_nettype wire

// ### dmrd_mode_regs_props.sv
/* checker of the mode register group ports.
   assumes binding into dmrd_mode_regs. */
`timescale 1ns/10ps
`default_nettype none
module dmrd_mode_regs_props
    import dmrd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic lnk_clk,
    input wire logic mode_write_command,
    input wire logic term_value_ca_enable,
    input wire logic cal_active,
    input wire logic cal_bit,
    input wire logic dbi_read_enable,
    input wire logic mrw_busy,
    input wire logic mrw_applied,
    input wire dmrd_byte_t dq_cal_upper,
    input wire logic upper_mask_invert_lane,
    input wire logic dbi_apply,
    input wire dmrd_odt_code_t soc_odt_code,
    input wire logic soc_odt_enable,
    input wire logic soc_odt_reserved,
    input wire logic ck_term_en,
    input wire logic cs_term_en,
    input wire logic ca_term_en
);
    logic [1:0] settle_r;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            settle_r <= 2'h0;
        end else if (settle_r != 2'h3) begin
            settle_r <= settle_r + 2'h1;
        end
    end
    sequence quiet_s;
        settle_r == 2'h3 && !mrw_busy && !$past(mrw_busy);
    endsequence
    sequence flip_s;
        $past(cal_bit) != $past(cal_bit, 2);
    endsequence
    sequence tve_off_s;
        (!term_value_ca_enable) [*3];
    endsequence
    sequence req_s;
        mode_write_command && !mrw_busy;
    endsequence
    true_lane_a: assert property (@(posedge sys_clk) disable iff (srst)
        settle_r == 2'h3 |-> upper_mask_invert_lane == $past(cal_bit))
        else $error("mask lane not true");
    invert_flip_a: assert property (@(posedge sys_clk) disable iff (srst)
        quiet_s ##0 flip_s |-> dq_cal_upper == ~$past(dq_cal_upper))
        else $error("lanes did not follow pattern");
    dbi_off_a: assert property (@(posedge sys_clk) disable iff (srst)
        settle_r == 2'h3 |-> dbi_apply == $past(dbi_read_enable && !cal_active))
        else $error("inversion during calibration");
    odt_code_a: assert property (@(posedge sys_clk) disable iff (srst)
        soc_odt_reserved == (soc_odt_code == 3'h7) &&
        soc_odt_enable == (soc_odt_code != 3'h0 && soc_odt_code != 3'h7))
        else $error("odt code flags wrong");
    term_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
        tve_off_s |-> !ck_term_en && !cs_term_en && !ca_term_en)
        else $error("termination without enable");
    applied_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
        mrw_applied |=> !mrw_applied)
        else $error("applied longer than one cycle");
    applied_busy_a: assert property (@(posedge sys_clk) disable iff (srst)
        mrw_applied |-> $past(mrw_busy))
        else $error("applied outside a write");
    busy_rise_a: assert property (@(posedge lnk_clk) disable iff (srst)
        req_s |-> ##[1:2] mrw_busy)
        else $error("write not taken");
    busy_bound_a: assert property (@(posedge lnk_clk) disable iff (srst)
        $rose(mrw_busy) |-> ##[1:80] !mrw_busy)
        else $error("write never completed");
endmodule
bind dmrd_mode_regs dmrd_mode_regs_props props_u (.sys_clk(sys_clk), .srst(srst),
    .lnk_clk(lnk_clk), .mode_write_command(mode_write_command), .cal_bit(cal_bit),
    .term_value_ca_enable(term_value_ca_enable), .cal_active(cal_active),
    .dbi_read_enable(dbi_read_enable), .mrw_busy(mrw_busy), .mrw_applied(mrw_applied),
    .dq_cal_upper(dq_cal_upper), .upper_mask_invert_lane(upper_mask_invert_lane),
    .dbi_apply(dbi_apply), .soc_odt_code(soc_odt_code), .soc_odt_enable(soc_odt_enable),
    .soc_odt_reserved(soc_odt_reserved), .ck_term_en(ck_term_en),
    .cs_term_en(cs_term_en), .ca_term_en(ca_term_en));
`default_nettype wire

// ### dmrd_ctrl_model.sv
/* controller model issuing mode register writes on the link clock.
   assumes go is held until done rises. */
`timescale 1ns/10ps
`default_nettype none
module dmrd_ctrl_model
    import dmrd_pkg::*;
(
    input wire logic lnk_clk,
    input wire logic go,
    input wire dmrd_addr_t a,
    input wire dmrd_byte_t d,
    input wire logic w,
    input wire logic busy,
    output logic cmd,
    output dmrd_addr_t addr,
    output dmrd_byte_t op,
    output logic wsel,
    output logic done
);
    initial begin
        cmd = 1'b0;
        addr = 6'h00;
        op = 8'h00;
        wsel = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge lnk_clk iff go);
            #1;
            cmd = 1'b1;
            addr = a;
            op = d;
            wsel = w;
            @(posedge lnk_clk);
            #1;
            // released lines show no stale value
            cmd = 1'b0;
            addr = ~addr;
            op = ~op;
            wsel = ~wsel;
            repeat (16) @(posedge lnk_clk);
            while (busy) @(posedge lnk_clk);
            done = 1'b1;
            wait (!go);
            done = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### tb_dram_mode_regs_dqcal_odt.sv
/* self-checking bench of the mode register group.
   assumes io config high-voltage select is 1, so only odt code 7 is reserved. */
`timescale 1ns/10ps
`default_nettype none
`include "dmrd_cfg.svh"
module tb_dram_mode_regs_dqcal_odt
    import dmrd_pkg::*;
;
    logic sys_clk = 0, srst = 1, lnk_clk = 0, go = 0, gw = 0, osel = 0, tve = 0;
    logic bmode = 0, upb = 0, bond = 0, cal = 0, act = 0, dbi = 0;
    logic cmd, wsel, done, busy, appl, mask, dbia, lss, oen, ores, ck, cs, ca, bsn;
    dmrd_addr_t ga = 6'h00, maddr;
    dmrd_byte_t gd = 8'h00, mop, dq, inv;
    dmrd_byte_t spd [2];
    dmrd_byte_t trm [2];
    dmrd_odt_code_t code;
    int bad_count = 0, num_checks = 0, cyc = 0, i;
    logic [31:0] rs = 72, r;
    dmrd_mode_regs dut_u (.sys_clk(sys_clk), .srst(srst), .lnk_clk(lnk_clk),
        .mode_write_command(cmd), .mrw_addr(maddr), .mrw_op(mop),
        .write_set_point_select(wsel), .operating_set_point_select(osel),
        .term_value_ca_enable(tve), .byte_mode(bmode), .upper_byte_device(upb),
        .term_bond_pin(bond), .cal_active(act), .cal_bit(cal), .dbi_read_enable(dbi),
        .mrw_busy(busy), .mrw_applied(appl), .dq_cal_upper(dq),
        .upper_mask_invert_lane(mask), .dbi_apply(dbia), .ca_low_speed_sel(lss),
        .soc_odt_code(code), .soc_odt_enable(oen), .soc_odt_reserved(ores),
        .ck_term_en(ck), .cs_term_en(cs), .ca_term_en(ca), .term_bond_seen(bsn));
    dmrd_ctrl_model ctl_u (.lnk_clk(lnk_clk), .go(go), .a(ga), .d(gd), .w(gw),
        .busy(busy), .cmd(cmd), .addr(maddr), .op(mop), .wsel(wsel), .done(done));
    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        #3.7;
        forever #6 lnk_clk = ~lnk_clk;
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input dmrd_addr_t a, input dmrd_byte_t d, input logic w);
        int n;
        n = 0;
        ga = a;
        gd = d;
        gw = w;
        go = 1'b1;
        while (done !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        go = 1'b0;
        if (done !== 1'b1) begin
            bad_count++;
            test_done();
        end
        if (a == `DMRD_ADDR_UPPER_INVERT) inv = d;
        if (a == `DMRD_ADDR_CA_SPEED) spd[w] = d & 8'h20;
        if (a == `DMRD_ADDR_TERM_CTRL) trm[w] = d;
        // let the echo reach the link before the next request
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic check_all();
        dmrd_byte_t t;
        logic off;
        t = trm[osel];
        off = bmode & (upb ? t[7] : t[6]);
        repeat (3) @(negedge sys_clk);
        chk(8'(lss), 8'(spd[osel][5]));
        chk(8'(code), 8'(t[2:0]));
        chk(8'(oen), 8'(t[2:0] != 3'h0 && t[2:0] != 3'h7));
        chk(8'(ores), 8'(t[2:0] == 3'h7));
        chk(8'(ck), 8'(tve & ~t[3] & ~off));
        chk(8'(cs), 8'(tve & ~t[4] & ~off));
        chk(8'(ca), 8'(tve & ~t[5] & ~off));
        chk(8'(bsn), 8'(bond));
        repeat (3) begin
            r = rnd();
            cal = r[0];
            act = r[1];
            dbi = r[2];
            @(negedge sys_clk);
            chk(dq, {8{cal}} ^ inv);
            chk(8'(mask), 8'(cal));
            chk(8'(dbia), 8'(dbi & ~act));
        end
    endtask
    task automatic do_reset();
        srst = 1'b1;
        repeat (10) @(negedge sys_clk);
        srst = 1'b0;
        inv = `DMRD_RST_UPPER_INVERT;
        spd = '{8'h00, 8'h00};
        trm = '{8'h00, 8'h00};
        repeat (4) @(negedge sys_clk);
        check_all();
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        do_reset();
        wr(`DMRD_ADDR_TERM_CTRL, 8'h00, 1'b1);
        tve = 1'b1;
        check_all();
        for (i = 0; i < 30; i++) begin
            r = rnd();
            {osel, bmode, upb, tve, bond} = r[12:8];
            ga = (r[1:0] == 2'h3) ? (r[2] ? 6'h13 : 6'h17) : 6'h14 + 6'(r[1:0]);
            gd = r[23:16];
            if (ga == `DMRD_ADDR_CA_SPEED) gd[5] = 1'b0;
            wr(ga, gd, r[3]);
            check_all();
        end
        for (i = 0; i < 8; i++) begin
            wr(`DMRD_ADDR_TERM_CTRL, 8'(i) | 8'hA8, osel);
            check_all();
        end
        tve = 1'b0;
        wr(`DMRD_ADDR_CA_SPEED, 8'hFF, osel);
        check_all();
        wr(`DMRD_ADDR_CA_SPEED, 8'h00, ~osel);
        check_all();
        do_reset();
        test_done();
    end
endmodule
`default_nettype wire
